// ==== esc_exec_defines.svh ====
// Function
// [RQ1] Opcode byte A5 hex is an escape prefix; next byte picks the extended operation.
// [RQ2] Software should not use stray escape bytes as filler; they are not no-ops.
// [RQ3] Arithmetic right shift of MAC register keeps bit 39; 2 bytes, 2 cycles, no flags.
// [RQ4] With debug enabled, breakpoint halts before next instruction, PC advanced by 2.
// [RQ5] With debug disabled, breakpoint (A5 00) acts as double no-op, 2 cycles, no flags.
// [RQ6] Extended compare branch tests accumulator against @R0/@R1; branches when unequal.
// [RQ7] Target is advanced PC plus signed last byte; 3 bytes, 18 compat, 4 fast clocks.
// [RQ8] Carry set when accumulator below operand, else cleared; operands unchanged.
// [RQ9] MAC clear zeroes all 40 bits, flags untouched.
// [RQ10] Clocks counted in divider output periods: fast divides by 1, compatibility by 2.
// [RQ11] Compatibility-mode external data move with wait state adds 24 clocks.
// [RQ12] Fast-mode external data move adds one clock per wait state, 0 to 3.
// [RQ13] Standard compare-immediate indirect branch B6-B7: 3 bytes, 12 compat, 4 fast clocks.
// [RQ14] Logical left shift of MAC register, zero into bit 0, no flags.
// [RQ15] MAC register is 40 bits and accumulates signed 32-bit products.
// [RQ16] Escape with undefined second byte is a two-byte no-op.
`ifndef ESC_EXEC_DEFINES_SVH
`define ESC_EXEC_DEFINES_SVH
`define ESC_PREFIX 8'hA5
`define OP_BREAK 8'h00
`define OP_ASR 8'h03
`define OP_LSL 8'h23
`define OP_MAC 8'hA4
`define OP_CLR 8'hE4
`define OP_CJ_R0 8'hB6
`define OP_CJ_R1 8'hB7
`define OP_XMOV_ALT_RD 8'hE0
`define OP_XMOV_ALT_WR 8'hF0
`define CYC_MACSHIFT_FAST 5'h02
`define CYC_MACSHIFT_COMPAT 5'h02
`define CYC_MAC_FAST 5'h09
`define CYC_XCJ_FAST 5'h04
`define CYC_XCJ_COMPAT 5'h12
`define CYC_CJI_FAST 5'h04
`define CYC_CJI_COMPAT 5'h0C
`define CYC_XMOV_FAST 5'h05
`define CYC_XMOV_COMPAT 5'h12
`define CYC_XWAIT_COMPAT 6'h18
`define DIV_FAST 2'h1
`define DIV_COMPAT 2'h2
`define BYTES_XCJ 2'h3
`define BYTES_ESC2 2'h2
`define MAC_W 40
`endif

// ==== esc_exec_pkg.sv ====
package esc_exec_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ESC, ST_DISP, ST_WAIT} exec_state_e;
  typedef enum logic [3:0] {
    XOP_NONE, XOP_BREAK, XOP_ASR, XOP_LSL, XOP_CLR, XOP_MAC, XOP_XCJ, XOP_CJI, XOP_XMOV, XOP_NOP2
  } xop_e;
endpackage : esc_exec_pkg

// ==== clk_divider.sv ====
`timescale 1ns/100ps
`include "esc_exec_defines.svh"
// Clock divider producing one-cycle enables; ratio 1 or 2 by mode.
module clk_divider
  import esc_exec_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic fast_mode,
  output logic clk_en
);
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  wire [1:0] ratio = fast_mode ? `DIV_FAST : `DIV_COMPAT; // RQ10
  wire wrap = (cnt_ff + 2'd1 >= ratio);
  assign nxt_cnt = wrap ? 2'd0 : cnt_ff + 2'd1;
  assign clk_en = wrap;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) cnt_ff <= 2'd0;
    else cnt_ff <= nxt_cnt;
  end
  div_fast_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ10
    fast_mode |-> clk_en) else $error("fast mode enable not every cycle");
  // A switch to fast mode may legally bring the next enable at once
  div_compat_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ10
    (!fast_mode && clk_en && $past(!fast_mode)) |=> (fast_mode || !clk_en))
    else $error("compat enable too dense");
endmodule : clk_divider

// ==== esc_exec.sv ====
`timescale 1ns/100ps
`include "esc_exec_defines.svh"
module esc_exec
  import esc_exec_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic fast_mode_pin,
  input wire logic debug_enable_pin,
  input wire logic [1:0] wait_states_pin,
  input wire logic xmem_wait_pin,
  input wire logic op_valid,
  input wire logic [7:0] op_byte,
  input wire logic [7:0] disp_byte,
  input wire logic [7:0] acc,
  input wire logic [7:0] ind_ram,
  input wire logic [15:0] pc_in,
  input wire logic [31:0] mac_product,
  output logic busy,
  output logic done,
  output logic debug_halt,
  output logic pc_load,
  output logic [15:0] pc_out,
  output logic carry_we,
  output logic carry_out,
  output logic ind_sel,
  output logic [`MAC_W-1:0] mac_reg,
  output logic [5:0] last_cycles
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] fast_s_ff, dbg_s_ff, xw_s_ff;
  logic [1:0] ws0_s_ff, ws1_s_ff;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fast_s_ff <= 2'h0;
      dbg_s_ff <= 2'h0;
      xw_s_ff <= 2'h0;
      ws0_s_ff <= 2'h0;
      ws1_s_ff <= 2'h0;
    end else begin
      fast_s_ff <= {fast_s_ff[0], fast_mode_pin};
      dbg_s_ff <= {dbg_s_ff[0], debug_enable_pin};
      xw_s_ff <= {xw_s_ff[0], xmem_wait_pin};
      ws0_s_ff <= {ws0_s_ff[0], wait_states_pin[0]};
      ws1_s_ff <= {ws1_s_ff[0], wait_states_pin[1]};
    end
  end
  wire fast_mode = fast_s_ff[1];
  wire dbg_en = dbg_s_ff[1];
  wire xmem_wait = xw_s_ff[1];
  wire [1:0] wait_states = {ws1_s_ff[1], ws0_s_ff[1]};
  wire clk_en;
  clk_divider u_div (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .fast_mode(fast_mode),
    .clk_en(clk_en)
  );
  // ****************************************
  // Decode
  // ****************************************
  exec_state_e state_ff, nxt_state;
  xop_e op_ff, nxt_op;
  logic [5:0] cnt_ff;
  logic [5:0] left_ff;
  logic [7:0] opnd_ff;
  wire take = op_valid && clk_en;
  wire is_prefix = (op_byte == `ESC_PREFIX); // RQ1
  wire is_cji = (op_byte[7:1] == 7'h5B); // RQ13
  xop_e ext_op;
  always_comb begin
    unique case (op_byte) // RQ1
      `OP_BREAK: ext_op = XOP_BREAK;
      `OP_ASR: ext_op = XOP_ASR;
      `OP_LSL: ext_op = XOP_LSL;
      `OP_CLR: ext_op = XOP_CLR;
      `OP_MAC: ext_op = XOP_MAC;
      `OP_CJ_R0, `OP_CJ_R1: ext_op = XOP_XCJ; // RQ6
      `OP_XMOV_ALT_RD, `OP_XMOV_ALT_WR: ext_op = XOP_XMOV;
      default: ext_op = XOP_NOP2; // RQ16
    endcase
  end
  // Cycle totals per operation and mode
  wire [5:0] xmov_extra = fast_mode ? {4'h0, wait_states} // RQ12
                        : (xmem_wait ? `CYC_XWAIT_COMPAT : 6'h0); // RQ11
  logic [5:0] op_cycles;
  always_comb begin
    unique case (ext_op)
      XOP_XCJ: op_cycles = fast_mode ? 6'(`CYC_XCJ_FAST) : 6'(`CYC_XCJ_COMPAT); // RQ7
      XOP_MAC: op_cycles = 6'(`CYC_MAC_FAST);
      XOP_XMOV: op_cycles = (fast_mode ? 6'(`CYC_XMOV_FAST) : 6'(`CYC_XMOV_COMPAT)) + xmov_extra;
      default: op_cycles = 6'(`CYC_MACSHIFT_FAST); // RQ3 RQ5
    endcase
  end
  wire [5:0] cji_cycles = fast_mode ? 6'(`CYC_CJI_FAST) : 6'(`CYC_CJI_COMPAT); // RQ13
  // Prefix consumes one clock; the rest is counted down in ST_WAIT.
  always_comb begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    unique case (state_ff)
      ST_IDLE: if (take && is_prefix) nxt_state = ST_ESC;
        else if (take && is_cji) begin
          nxt_state = ST_WAIT;
          nxt_op = XOP_CJI;
        end
      ST_ESC: if (take) begin
          nxt_state = ST_WAIT;
          nxt_op = ext_op;
        end
      ST_DISP: nxt_state = ST_IDLE;
      ST_WAIT: if (clk_en && left_ff <= 6'd1) nxt_state = ST_IDLE;
    endcase
  end
  wire finish = (state_ff == ST_WAIT) && clk_en && (left_ff <= 6'd1);
  // ****************************************
  // Execution
  // ****************************************
  wire [`MAC_W-1:0] prod_ext = {{(`MAC_W-32){mac_product[31]}}, mac_product};
  logic [`MAC_W-1:0] nxt_mac;
  always_comb begin
    nxt_mac = mac_reg;
    if (finish) begin
      unique case (op_ff)
        XOP_ASR: nxt_mac = {mac_reg[`MAC_W-1], mac_reg[`MAC_W-1:1]}; // RQ3
        XOP_LSL: nxt_mac = {mac_reg[`MAC_W-2:0], 1'b0}; // RQ14
        XOP_CLR: nxt_mac = '0; // RQ9
        XOP_MAC: nxt_mac = mac_reg + prod_ext; // RQ15
        default: nxt_mac = mac_reg;
      endcase
    end
  end
  wire is_cmp = (op_ff == XOP_XCJ) || (op_ff == XOP_CJI);
  // Compare sources: extended form uses acc, standard form the latched opnd_ff; both against ind_ram
  wire [7:0] rhs = ind_ram;
  // Standard form's rel byte arrives as last byte; latched opnd_ff holds the last byte taken, the B6/B7 opcode
  wire [7:0] cmp_lhs = (op_ff == XOP_XCJ) ? acc : opnd_ff;
  wire unequal = (cmp_lhs != rhs); // RQ6
  wire below = (cmp_lhs < rhs); // RQ8
  wire [15:0] target = pc_in + {{8{disp_byte[7]}}, disp_byte}; // RQ7
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      op_ff <= XOP_NONE;
      left_ff <= 6'h0;
      cnt_ff <= 6'h00;
      opnd_ff <= 8'h0;
    end else begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      if (state_ff == ST_ESC && take) left_ff <= op_cycles - 6'd1;
      else if (state_ff == ST_IDLE && take && is_cji) left_ff <= cji_cycles;
      else if (state_ff == ST_WAIT && clk_en) left_ff <= left_ff - 6'd1;
      if (state_ff == ST_IDLE && take) cnt_ff <= 6'h01;
      else if (state_ff != ST_IDLE && clk_en) cnt_ff <= cnt_ff + 6'h01;
      if (take) opnd_ff <= op_byte;
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mac_reg <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      debug_halt <= 1'b0;
      pc_load <= 1'b0;
      pc_out <= 16'h0;
      carry_we <= 1'b0;
      carry_out <= 1'b0;
      ind_sel <= 1'b0;
      last_cycles <= 6'h00;
    end else begin
      mac_reg <= nxt_mac;
      busy <= (nxt_state != ST_IDLE);
      done <= finish;
      debug_halt <= finish && (op_ff == XOP_BREAK) && dbg_en; // RQ4 RQ5
      pc_load <= finish && is_cmp && unequal; // RQ6
      pc_out <= (finish && is_cmp) ? target : pc_in; // RQ4 PC already past the 2 bytes
      carry_we <= finish && is_cmp; // RQ8
      carry_out <= (finish && is_cmp) ? below : carry_out; // RQ8
      if (state_ff == ST_ESC && take) ind_sel <= op_byte[0];
      if (finish) last_cycles <= cnt_ff;
    end
  end
  // ****************************************
  // Checks
  // ****************************************
  asr_sign_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ3
    (finish && op_ff == XOP_ASR) |=> (mac_reg[39] == $past(mac_reg[39]) && mac_reg[38:0] == $past(mac_reg[39:1])))
    else $error("mac shift right wrong");
  lsl_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ14
    (finish && op_ff == XOP_LSL) |=> (mac_reg == {$past(mac_reg[38:0]), 1'b0}))
    else $error("mac shift left wrong");
  clr_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ9
    (finish && op_ff == XOP_CLR) |=> mac_reg == 40'h0) else $error("mac clear wrong");
  mac_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ15
    !finish |=> $stable(mac_reg)) else $error("mac changed outside an op");
  brk_halt_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ5
    (finish && op_ff == XOP_BREAK && !dbg_en) |=> !debug_halt) else $error("break halted while disabled");
  brk_dbg_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ4
    (finish && op_ff == XOP_BREAK && dbg_en) |=> debug_halt) else $error("break did not halt");
  cmp_branch_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ6
    (finish && op_ff == XOP_XCJ) |=> (pc_load == $past(acc != ind_ram) && carry_out == $past(acc < ind_ram)))
    else $error("compare branch wrong");
  esc_seq_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ1
    (state_ff == ST_IDLE && take && is_prefix) |=> state_ff == ST_ESC) else $error("prefix not escaped");
  xcj_fast_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ7
    (finish && op_ff == XOP_XCJ && fast_mode) |=> last_cycles == 6'h04) else $error("fast compare cycles");
  nop2_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ16
    (finish && op_ff == XOP_NOP2) |=> !pc_load && !debug_halt) else $error("undefined escape acted");
  c_brk: cover property (@(posedge ref_clk) finish && op_ff == XOP_BREAK && dbg_en);
  c_xcj: cover property (@(posedge ref_clk) finish && op_ff == XOP_XCJ && !fast_mode);
  c_xmov: cover property (@(posedge ref_clk) finish && op_ff == XOP_XMOV && wait_states == 2'd3);
  c_asr: cover property (@(posedge ref_clk) finish && op_ff == XOP_ASR && mac_reg[39]);
endmodule : esc_exec

// ==== esc_exec_tb_top.sv ====
`timescale 1ns/100ps
`include "esc_exec_defines.svh"
module esc_exec_tb_top
  import esc_exec_pkg::*;
;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic fast_mode_pin = 1'b1;
  logic debug_enable_pin = 1'b0;
  logic [1:0] wait_states_pin = 2'h0;
  logic xmem_wait_pin = 1'b0;
  logic op_valid = 1'b0;
  logic [7:0] op_byte = 8'h00;
  logic [7:0] disp_byte = 8'h00;
  logic [7:0] acc = 8'h00;
  logic [7:0] ind_ram = 8'h00;
  logic [15:0] pc_in = 16'h0000;
  logic [31:0] mac_product = 32'h00000000;
  logic busy, done, debug_halt, pc_load, carry_we, carry_out, ind_sel;
  logic [15:0] pc_out;
  logic [`MAC_W-1:0] mac_reg;
  logic [5:0] last_cycles;
  logic done_seen, halt_seen, load_seen, we_seen;
  logic [15:0] load_pc;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int div = 1;

  esc_exec i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .fast_mode_pin(fast_mode_pin),
    .debug_enable_pin(debug_enable_pin), .wait_states_pin(wait_states_pin), .xmem_wait_pin(xmem_wait_pin),
    .op_valid(op_valid), .op_byte(op_byte), .disp_byte(disp_byte), .acc(acc), .ind_ram(ind_ram),
    .pc_in(pc_in), .mac_product(mac_product), .busy(busy), .done(done), .debug_halt(debug_halt),
    .pc_load(pc_load), .pc_out(pc_out), .carry_we(carry_we), .carry_out(carry_out), .ind_sel(ind_sel),
    .mac_reg(mac_reg), .last_cycles(last_cycles));

  always #5 ref_clk = ~ref_clk;

  // Pulses are caught mid-cycle, away from the launching edge
  always @(negedge ref_clk) begin
    if (done === 1'b1) done_seen = 1'b1;
    if (debug_halt === 1'b1) halt_seen = 1'b1;
    if (pc_load === 1'b1) begin
      load_seen = 1'b1;
      load_pc = pc_out;
    end
    if (carry_we === 1'b1) we_seen = 1'b1;
  end

  task summarize;
    $display("Checks %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end

  task chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Each byte held for one full divided clock so exactly one enable takes it
  task run(input logic [7:0] b0, input logic [7:0] b1, input logic esc);
    int i;
    done_seen = 1'b0;
    halt_seen = 1'b0;
    load_seen = 1'b0;
    we_seen = 1'b0;
    op_valid <= 1'b1;
    op_byte <= b0;
    repeat (div) @(posedge ref_clk);
    if (esc) begin
      op_byte <= b1;
      repeat (div) @(posedge ref_clk);
    end
    op_valid <= 1'b0;
    for (i = 0; i < 200 && done_seen !== 1'b1; i++) @(posedge ref_clk);
    chk("done", 1'b1, done_seen);
  endtask : run

  task set_mode(input logic fast, input logic dbg, input logic [1:0] ws, input logic xw);
    fast_mode_pin <= fast;
    debug_enable_pin <= dbg;
    wait_states_pin <= ws;
    xmem_wait_pin <= xw;
    div = fast ? 1 : 2;
    repeat (6) @(posedge ref_clk);
  endtask : set_mode

  task t_mac_ops;
    mac_product <= 32'h80000001;
    run(`ESC_PREFIX, `OP_MAC, 1'b1);
    chk("mac", 40'hFF80000001, mac_reg);
    chk("mac_cycles", 5'h09, last_cycles);
    run(`ESC_PREFIX, `OP_ASR, 1'b1);
    chk("asr", 40'hFFC0000000, mac_reg);
    chk("asr_cycles", 5'h02, last_cycles);
    chk("asr_flags", 1'b0, we_seen);
    run(`ESC_PREFIX, `OP_LSL, 1'b1);
    chk("lsl", 40'hFF80000000, mac_reg);
    mac_product <= 32'h7FFFFFFF;
    run(`ESC_PREFIX, `OP_MAC, 1'b1);
    chk("mac2", 40'hFFFFFFFFFF, mac_reg);
    run(`ESC_PREFIX, `OP_CLR, 1'b1);
    chk("clr", 40'h0000000000, mac_reg);
    chk("clr_flags", 1'b0, we_seen);
  endtask : t_mac_ops

  task t_break_undef;
    mac_product <= 32'h00001234;
    run(`ESC_PREFIX, `OP_MAC, 1'b1);
    pc_in <= 16'h2002;
    run(`ESC_PREFIX, `OP_BREAK, 1'b1);
    chk("brk_nohalt", 1'b0, halt_seen);
    chk("brk_cycles", 5'h02, last_cycles);
    chk("brk_mac", 40'h0000001234, mac_reg);
    chk("brk_flags", 1'b0, we_seen);
    run(`ESC_PREFIX, 8'h55, 1'b1);
    chk("undef_cycles", 5'h02, last_cycles);
    chk("undef_load", 1'b0, load_seen);
    chk("undef_mac", 40'h0000001234, mac_reg);
    set_mode(1'b1, 1'b1, 2'h0, 1'b0);
    run(`ESC_PREFIX, `OP_BREAK, 1'b1);
    chk("brk_halt", 1'b1, halt_seen);
    chk("brk_pc", 16'h2002, pc_out);
    set_mode(1'b1, 1'b0, 2'h0, 1'b0);
    // A lone prefix is no filler: the core sits waiting for its partner byte
    op_valid <= 1'b1;
    op_byte <= `ESC_PREFIX;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("stray_prefix_busy", 1'b1, busy);
    run(8'h55, 8'h00, 1'b0);
    chk("stray_prefix_load", 1'b0, load_seen);
  endtask : t_break_undef

  task xcj(input logic [7:0] op, input logic [7:0] a, input logic [7:0] r, input logic [7:0] d,
           input logic [15:0] pc, input logic [4:0] cyc_exp);
    acc <= a;
    ind_ram <= r;
    disp_byte <= d;
    pc_in <= pc;
    run(`ESC_PREFIX, op, 1'b1);
    chk("xcj_load", a != r, load_seen);
    if (a != r) chk("xcj_target", 16'(pc + {{8{d[7]}}, d}), load_pc);
    chk("xcj_carry", a < r, carry_out);
    chk("xcj_carry_we", 1'b1, we_seen);
    chk("xcj_sel", op[0], ind_sel);
    chk("xcj_cycles", cyc_exp, last_cycles);
  endtask : xcj

  task t_compare;
    xcj(`OP_CJ_R0, 8'h34, 8'h56, 8'hF0, 16'h1000, 5'h04);
    xcj(`OP_CJ_R1, 8'h56, 8'h56, 8'h10, 16'h1000, 5'h04);
    xcj(`OP_CJ_R1, 8'h90, 8'h12, 8'h7F, 16'hFFF0, 5'h04);
    run(8'hB6, 8'h00, 1'b0);
    chk("cji_fast", 5'h04, last_cycles);
  endtask : t_compare

  task t_xmov;
    int w;
    for (w = 0; w < 4; w++) begin
      set_mode(1'b1, 1'b0, w[1:0], 1'b0);
      run(`ESC_PREFIX, w[0] ? `OP_XMOV_ALT_WR : `OP_XMOV_ALT_RD, 1'b1);
      chk("xmov_fast", 5'h05 + w[4:0], last_cycles);
    end
  endtask : t_xmov

  task t_compat;
    set_mode(1'b0, 1'b0, 2'h3, 1'b0);
    xcj(`OP_CJ_R0, 8'h01, 8'h02, 8'h04, 16'h0100, 5'h12);
    run(8'hB7, 8'h00, 1'b0);
    chk("cji_compat", 5'h0C, last_cycles);
    run(`ESC_PREFIX, `OP_XMOV_ALT_RD, 1'b1);
    chk("xmov_compat", 5'h12, last_cycles);
    run(`ESC_PREFIX, `OP_ASR, 1'b1);
    chk("asr_compat", 5'h02, last_cycles);
    set_mode(1'b0, 1'b0, 2'h0, 1'b1);
    run(`ESC_PREFIX, `OP_XMOV_ALT_WR, 1'b1);
    chk("xmov_compat_wait", 6'h2A, last_cycles);
  endtask : t_compat

  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("rst_mac", 40'h0000000000, mac_reg);
    chk("rst_busy", 1'b0, busy);
    t_mac_ops();
    t_break_undef();
    t_compare();
    t_xmov();
    t_compat();
    summarize();
  end
endmodule : esc_exec_tb_top
